// ### include/ise_pkg.sv
// constants and types of the two-wire slave engine
package ise_pkg;
  // register port indices
  localparam logic [2:0] ADDR_MODE  = 3'h0;
  localparam logic [2:0] ADDR_STAT  = 3'h1;
  localparam logic [2:0] ADDR_DATA  = 3'h2;
  localparam logic [2:0] ADDR_OWN   = 3'h3;
  localparam logic [2:0] ADDR_TOUT  = 3'h4;
  // serial_mode_control fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 5;
  localparam int DEB_HI  = 3;
  localparam int DEB_LO  = 2;
  localparam int EN_BIT  = 1;
  localparam int ICF_BIT = 0;
  // slave_status_control fields
  localparam int HCF_BIT   = 7;
  localparam int ADDRESS_MATCH_FLAG_BIT  = 6;
  localparam int HBB_BIT   = 5;
  localparam int HTX_BIT   = 4;
  localparam int TRANSMIT_ACK_BIT_BIT  = 3;
  localparam int SRW_BIT   = 2;
  localparam int MATCH_WAKEUP_ENABLE_BIT = 1;
  localparam int RECEIVED_ACK_FLAG_BIT  = 0;
  // timeout_control_register fields
  localparam int TO_EN_BIT  = 7;
  localparam int TO_FLG_BIT = 6;
  localparam int TO_SEL_HI  = 5;
  // reset values
  localparam logic [7:0] MODE_RST = 8'hE0;
  localparam logic [7:0] STAT_RST = 8'h81;
  localparam logic [7:0] OWN_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] TOUT_RST = 8'h00;
  // codes
  localparam logic [2:0] MODE_I2C = 3'h6;
  localparam logic [1:0] DEB_OFF  = 2'h0;
  localparam logic [1:0] DEB_TWO  = 2'h1;
  localparam logic [2:0] LIM_NONE = 3'h0;
  localparam logic [2:0] LIM_TWO  = 3'h1;
  localparam logic [2:0] LIM_FOUR = 3'h3;
  localparam int LINE_SCL = 1;
  localparam int LINE_SDA = 0;
  // timeout unit is 32 periods of the slow clock
  localparam int CLK_HZ        = 100_000_000;
  localparam int FSUB_HZ       = 32_768;
  localparam int TOUT_DIV      = 32;
  localparam int TOUT_UNIT_CYC = CLK_HZ / FSUB_HZ * TOUT_DIV;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_HOLD = 3'b011,
    ST_RX   = 3'b100,
    ST_RACK = 3'b101,
    ST_TX   = 3'b110,
    ST_TACK = 3'b111
  } ise_state_e;
endpackage : ise_pkg

// ### rtl/ise_i2c_slave_engine.sv
// two-wire slave engine with register port
// Behaviour
// - clock input debounce: 00 none, 01 two clocks, 1x four clocks
// - debounce select only acts in two-wire slave mode 110
// - enable low releases both lines and idles the engine
// - enable rising keeps direction and transmit-ack bits, resets status flags
// - complete flag low while shifting, high plus interrupt after eight bits received or nine bits sent
// - match flag high on equal address, low on different
// - busy flag set on START, cleared on STOP
// - START is data falling while clock high; only the master makes it
// - after eight received bits, drive transmit-ack bit on ninth clock
// - first seven bits after START are the address, MSB first
// - eighth bit after START stored as master read flag
// - on match drive ack low as ninth bit and interrupt
// - read flag 1 means master reads, 0 means master writes
// - direction bit 0 receiver, 1 transmitter
// - after sending eight bits sample ninth clock into received-ack flag
// - no ack from master releases data line for STOP
// - hold clock low until data write (transmit) or data read (receive)
// - match with wake-up enabled wakes the chip
// - one interrupt from match, byte done and time-out
// - mode register bit 4 reads as zero
// - own address in bits 7..1, bit 0 stored but not compared
// - time-out counter: overflow sets flag, clears enable, resets engine
module ise_i2c_slave_engine #(
  parameter int unsigned TOUT_UNIT_CYC = ise_pkg::TOUT_UNIT_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // bus clock line
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_n,
  // bus data line
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  // events
  output logic            irq,
  output logic            wake
);
  localparam int UW = $clog2(TOUT_UNIT_CYC + 1);

  ise_pkg::ise_state_e state_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] fil_q;
  logic [1:0] prev_q;
  logic [2:0] deb_cnt_q [2];
  logic [2:0] deb_lim;
  logic [2:0] mode_q;
  logic [1:0] deb_q;
  logic       en_q;
  logic       icf_q;
  logic [7:0] own_q;
  logic       htx_q;
  logic       transmit_ack_bit_q;
  logic       match_wakeup_enable_q;
  logic       hcf_q;
  logic       address_match_flag_q;
  logic       hbb_q;
  logic       srw_q;
  logic       received_ack_flag_q;
  logic [7:0] data_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic       en_prev_q;
  logic       sda_oe_n_q;
  logic       scl_oe_n_q;
  logic       zero_q;
  logic       irq_q;
  logic       wake_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;
  logic       to_en_q;
  logic       to_flag_q;
  logic [5:0] to_sel_q;
  logic       to_run_q;
  logic [UW-1:0] unit_cnt_q;
  logic [5:0] per_cnt_q;
  logic       mode_i2c;
  logic       active;
  logic       en_rise;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda_now;
  logic       start_det;
  logic       stop_det;
  logic       addr_hit;
  logic       sw_release;
  logic       unit_tick;
  logic       to_hit;

  assign mode_i2c = (mode_q == ise_pkg::MODE_I2C);
  assign active   = mode_i2c && en_q;
  assign en_rise  = active && !en_prev_q;
  assign sda_now  = fil_q[ise_pkg::LINE_SDA];
  assign scl_rise = fil_q[ise_pkg::LINE_SCL] && !prev_q[ise_pkg::LINE_SCL];
  assign scl_fall = !fil_q[ise_pkg::LINE_SCL] && prev_q[ise_pkg::LINE_SCL];
  // conditions need the clock line high on both samples
  assign start_det = fil_q[ise_pkg::LINE_SCL] && prev_q[ise_pkg::LINE_SCL] &&
                     prev_q[ise_pkg::LINE_SDA] && !sda_now;
  assign stop_det  = fil_q[ise_pkg::LINE_SCL] && prev_q[ise_pkg::LINE_SCL] &&
                     !prev_q[ise_pkg::LINE_SDA] && sda_now;
  assign addr_hit = (state_q == ise_pkg::ST_ADDR) && scl_rise && (cnt_q == 4'h7) &&
                    (shift_q[6:0] == own_q[7:1]);
  assign sw_release = (state_q == ise_pkg::ST_HOLD) && (reg_addr == ise_pkg::ADDR_DATA) &&
                      ((reg_wr && htx_q) || (reg_rd && !htx_q));
  assign unit_tick = (unit_cnt_q == UW'(TOUT_UNIT_CYC - 1));
  assign to_hit    = to_run_q && unit_tick && (per_cnt_q == to_sel_q);

  // debounce limit, only honoured in two-wire slave mode
  always_comb begin
    if (!mode_i2c || deb_q == ise_pkg::DEB_OFF) begin
      deb_lim = ise_pkg::LIM_NONE;
    end else if (deb_q == ise_pkg::DEB_TWO) begin
      deb_lim = ise_pkg::LIM_TWO;
    end else begin
      deb_lim = ise_pkg::LIM_FOUR;
    end
  end

  // line synchroniser and filter, both lines alike
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q      <= 2'h3;
      sync2_q      <= 2'h3;
      fil_q        <= 2'h3;
      prev_q       <= 2'h3;
      deb_cnt_q[0] <= 3'h0;
      deb_cnt_q[1] <= 3'h0;
    end else begin
      sync1_q <= {scl_i, sda_i};
      sync2_q <= sync1_q;
      prev_q  <= fil_q;
      for (int i = 0; i < 2; i++) begin
        if (sync2_q[i] == fil_q[i]) begin
          deb_cnt_q[i] <= 3'h0;
        end else if (deb_cnt_q[i] >= deb_lim) begin
          fil_q[i]     <= sync2_q[i];
          deb_cnt_q[i] <= 3'h0;
        end else begin
          deb_cnt_q[i] <= deb_cnt_q[i] + 3'h1;
        end
      end
    end
  end

  // software control bits
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q  <= ise_pkg::MODE_RST[ise_pkg::MODE_HI:ise_pkg::MODE_LO];
      deb_q   <= ise_pkg::MODE_RST[ise_pkg::DEB_HI:ise_pkg::DEB_LO];
      en_q    <= ise_pkg::MODE_RST[ise_pkg::EN_BIT];
      icf_q   <= ise_pkg::MODE_RST[ise_pkg::ICF_BIT];
      own_q   <= ise_pkg::OWN_RST;
      htx_q   <= ise_pkg::STAT_RST[ise_pkg::HTX_BIT];
      transmit_ack_bit_q  <= ise_pkg::STAT_RST[ise_pkg::TRANSMIT_ACK_BIT_BIT];
      match_wakeup_enable_q <= ise_pkg::STAT_RST[ise_pkg::MATCH_WAKEUP_ENABLE_BIT];
    end else begin
      if (reg_wr && reg_addr == ise_pkg::ADDR_MODE) begin
        mode_q <= reg_wdata[ise_pkg::MODE_HI:ise_pkg::MODE_LO];
        deb_q  <= reg_wdata[ise_pkg::DEB_HI:ise_pkg::DEB_LO];
        en_q   <= reg_wdata[ise_pkg::EN_BIT];
        icf_q  <= reg_wdata[ise_pkg::ICF_BIT];
      end
      if (reg_wr && reg_addr == ise_pkg::ADDR_OWN) begin
        own_q <= reg_wdata;
      end
      if (to_hit) begin
        htx_q   <= ise_pkg::STAT_RST[ise_pkg::HTX_BIT];
        transmit_ack_bit_q  <= ise_pkg::STAT_RST[ise_pkg::TRANSMIT_ACK_BIT_BIT];
        match_wakeup_enable_q <= ise_pkg::STAT_RST[ise_pkg::MATCH_WAKEUP_ENABLE_BIT];
      end else if (reg_wr && reg_addr == ise_pkg::ADDR_STAT) begin
        htx_q   <= reg_wdata[ise_pkg::HTX_BIT];
        transmit_ack_bit_q  <= reg_wdata[ise_pkg::TRANSMIT_ACK_BIT_BIT];
        match_wakeup_enable_q <= reg_wdata[ise_pkg::MATCH_WAKEUP_ENABLE_BIT];
      end
    end
  end

  // bus engine, status flags and line drivers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q    <= ise_pkg::ST_IDLE;
      hcf_q      <= ise_pkg::STAT_RST[ise_pkg::HCF_BIT];
      address_match_flag_q     <= ise_pkg::STAT_RST[ise_pkg::ADDRESS_MATCH_FLAG_BIT];
      hbb_q      <= ise_pkg::STAT_RST[ise_pkg::HBB_BIT];
      srw_q      <= ise_pkg::STAT_RST[ise_pkg::SRW_BIT];
      received_ack_flag_q     <= ise_pkg::STAT_RST[ise_pkg::RECEIVED_ACK_FLAG_BIT];
      data_q     <= ise_pkg::DATA_RST;
      shift_q    <= ise_pkg::DATA_RST;
      cnt_q      <= 4'h0;
      en_prev_q  <= 1'b0;
      sda_oe_n_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
      zero_q     <= 1'b0;
      irq_q      <= 1'b0;
      wake_q     <= 1'b0;
    end else begin
      irq_q     <= 1'b0;
      wake_q    <= 1'b0;
      zero_q    <= 1'b0;
      en_prev_q <= active;
      if (reg_wr && reg_addr == ise_pkg::ADDR_DATA) begin
        data_q <= reg_wdata;
      end
      if (!active || en_rise || to_hit) begin
        state_q    <= ise_pkg::ST_IDLE;
        sda_oe_n_q <= 1'b1;
        scl_oe_n_q <= 1'b1;
        if (en_rise || to_hit) begin
          hcf_q  <= ise_pkg::STAT_RST[ise_pkg::HCF_BIT];
          address_match_flag_q <= ise_pkg::STAT_RST[ise_pkg::ADDRESS_MATCH_FLAG_BIT];
          hbb_q  <= ise_pkg::STAT_RST[ise_pkg::HBB_BIT];
          srw_q  <= ise_pkg::STAT_RST[ise_pkg::SRW_BIT];
          received_ack_flag_q <= ise_pkg::STAT_RST[ise_pkg::RECEIVED_ACK_FLAG_BIT];
        end
        irq_q <= to_hit;
      end else if (start_det) begin
        hbb_q      <= 1'b1;
        state_q    <= ise_pkg::ST_ADDR;
        cnt_q      <= 4'h0;
        hcf_q      <= 1'b0;
        sda_oe_n_q <= 1'b1;
        scl_oe_n_q <= 1'b1;
      end else if (stop_det) begin
        hbb_q      <= 1'b0;
        state_q    <= ise_pkg::ST_IDLE;
        sda_oe_n_q <= 1'b1;
        scl_oe_n_q <= 1'b1;
      end else begin
        case (state_q)
          ise_pkg::ST_ADDR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_now};
              cnt_q   <= cnt_q + 4'h1;
              if (cnt_q == 4'h7) begin
                hcf_q  <= 1'b1;
                address_match_flag_q <= addr_hit;
                if (addr_hit) begin
                  srw_q  <= sda_now;
                  irq_q  <= 1'b1;
                  wake_q <= match_wakeup_enable_q;
                end
              end
            end else if (scl_fall && cnt_q == 4'h8) begin
              if (address_match_flag_q) begin
                sda_oe_n_q <= 1'b0;
                state_q    <= ise_pkg::ST_AACK;
              end else begin
                state_q <= ise_pkg::ST_IDLE;
              end
            end
          end
          ise_pkg::ST_AACK, ise_pkg::ST_RACK: begin
            if (scl_fall) begin
              sda_oe_n_q <= 1'b1;
              scl_oe_n_q <= 1'b0;
              state_q    <= ise_pkg::ST_HOLD;
            end
          end
          ise_pkg::ST_HOLD: begin
            if (sw_release) begin
              scl_oe_n_q <= 1'b1;
              cnt_q      <= 4'h0;
              hcf_q      <= 1'b0;
              if (htx_q) begin
                shift_q    <= reg_wdata;
                sda_oe_n_q <= reg_wdata[7];
                state_q    <= ise_pkg::ST_TX;
              end else begin
                state_q <= ise_pkg::ST_RX;
              end
            end
          end
          ise_pkg::ST_RX: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_now};
              cnt_q   <= cnt_q + 4'h1;
              if (cnt_q == 4'h7) begin
                data_q <= {shift_q[6:0], sda_now};
                hcf_q  <= 1'b1;
                irq_q  <= 1'b1;
              end
            end else if (scl_fall && cnt_q == 4'h8) begin
              sda_oe_n_q <= transmit_ack_bit_q;
              state_q    <= ise_pkg::ST_RACK;
            end
          end
          ise_pkg::ST_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                sda_oe_n_q <= 1'b1;
                state_q    <= ise_pkg::ST_TACK;
              end else begin
                shift_q    <= {shift_q[6:0], 1'b0};
                sda_oe_n_q <= shift_q[6];
              end
            end
          end
          ise_pkg::ST_TACK: begin
            if (scl_rise) begin
              received_ack_flag_q <= sda_now;
              hcf_q  <= 1'b1;
              irq_q  <= 1'b1;
            end else if (scl_fall) begin
              if (received_ack_flag_q) begin
                state_q <= ise_pkg::ST_IDLE;
              end else begin
                scl_oe_n_q <= 1'b0;
                state_q    <= ise_pkg::ST_HOLD;
              end
            end
          end
          default: begin
            state_q <= ise_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // time-out counter and its register
  always_ff @(posedge clk) begin
    if (srst) begin
      to_en_q    <= ise_pkg::TOUT_RST[ise_pkg::TO_EN_BIT];
      to_flag_q  <= ise_pkg::TOUT_RST[ise_pkg::TO_FLG_BIT];
      to_sel_q   <= ise_pkg::TOUT_RST[ise_pkg::TO_SEL_HI:0];
      to_run_q   <= 1'b0;
      unit_cnt_q <= '0;
      per_cnt_q  <= 6'h0;
    end else begin
      if (reg_wr && reg_addr == ise_pkg::ADDR_TOUT) begin
        to_en_q   <= reg_wdata[ise_pkg::TO_EN_BIT];
        to_flag_q <= reg_wdata[ise_pkg::TO_FLG_BIT];
        to_sel_q  <= reg_wdata[ise_pkg::TO_SEL_HI:0];
      end
      if (to_hit) begin
        to_en_q   <= 1'b0;
        to_flag_q <= 1'b1;
        to_run_q  <= 1'b0;
      end else if (!active || stop_det || !to_en_q) begin
        to_run_q <= 1'b0;
      end else if (addr_hit || (to_run_q && scl_fall)) begin
        to_run_q   <= 1'b1;
        unit_cnt_q <= '0;
        per_cnt_q  <= 6'h0;
      end else if (to_run_q) begin
        if (unit_tick) begin
          unit_cnt_q <= '0;
          per_cnt_q  <= per_cnt_q + 6'h1;
        end else begin
          unit_cnt_q <= unit_cnt_q + UW'(1);
        end
      end
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      ise_pkg::ADDR_MODE: rd_mux = {mode_q, 1'b0, deb_q, en_q, icf_q};
      ise_pkg::ADDR_STAT: rd_mux = {hcf_q, address_match_flag_q, hbb_q, htx_q, transmit_ack_bit_q, srw_q, match_wakeup_enable_q, received_ack_flag_q};
      ise_pkg::ADDR_DATA: rd_mux = data_q;
      ise_pkg::ADDR_OWN:  rd_mux = own_q;
      ise_pkg::ADDR_TOUT: rd_mux = {to_en_q, to_flag_q, to_sel_q};
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign scl_o     = zero_q;
  assign sda_o     = zero_q;
  assign scl_oe_n  = scl_oe_n_q;
  assign sda_oe_n  = sda_oe_n_q;
  assign irq       = irq_q;
  assign wake      = wake_q;

  property p_deb_none;
    @(posedge clk) disable iff (srst)
    (mode_i2c && deb_q == 2'h0 && sync2_q != fil_q) |=> (fil_q == $past(sync2_q));
  endproperty
  a_deb_none: assert property (p_deb_none) else $error("filter delayed with debounce off");

  property p_deb_mode;
    @(posedge clk) disable iff (srst)
    (!mode_i2c && sync2_q != fil_q) |=> (fil_q == $past(sync2_q));
  endproperty
  a_deb_mode: assert property (p_deb_mode) else $error("debounce acted outside slave mode");

  property p_off_release;
    @(posedge clk) disable iff (srst)
    !active |=> (sda_oe_n_q && scl_oe_n_q && state_q == ise_pkg::ST_IDLE);
  endproperty
  a_off_release: assert property (p_off_release) else $error("lines held while disabled");

  property p_en_rise;
    @(posedge clk) disable iff (srst)
    en_rise |=> (hcf_q && !address_match_flag_q && !hbb_q && !srw_q && received_ack_flag_q && htx_q == $past(htx_q));
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("flags not reset on enable");

  property p_busy;
    @(posedge clk) disable iff (srst)
    (active && !en_rise && !to_hit) |-> (start_det |=> hbb_q) and (stop_det && !start_det |=> !hbb_q);
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag wrong after condition");

  property p_addr_ack;
    @(posedge clk) disable iff (srst)
    (active && !to_hit && !start_det && !stop_det && state_q == ise_pkg::ST_ADDR && scl_fall &&
     cnt_q == 4'h8 && address_match_flag_q) |=> (!sda_oe_n_q ##1 !sda_oe_n_q);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no ack driven on match");

  property p_rx_ack;
    @(posedge clk) disable iff (srst)
    (active && !to_hit && state_q == ise_pkg::ST_RX && scl_fall && cnt_q == 4'h8)
      |=> (sda_oe_n_q == $past(transmit_ack_bit_q) && state_q == ise_pkg::ST_RACK);
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("ninth bit not transmit ack");

  property p_rx_done;
    @(posedge clk) disable iff (srst)
    (active && !en_rise && !to_hit && state_q == ise_pkg::ST_RX && scl_rise && cnt_q == 4'h7)
      |=> (hcf_q && irq_q && data_q == $past({shift_q[6:0], sda_now}));
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("byte end not flagged");

  property p_nack;
    @(posedge clk) disable iff (srst)
    (active && !to_hit && state_q == ise_pkg::ST_TACK && scl_fall && received_ack_flag_q && !stop_det)
      |=> (sda_oe_n_q && scl_oe_n_q && state_q == ise_pkg::ST_IDLE);
  endproperty
  a_nack: assert property (p_nack) else $error("data line kept after no ack");

  property p_hold;
    @(posedge clk) disable iff (srst)
    (active && !to_hit && !start_det && !stop_det && state_q == ise_pkg::ST_HOLD && !sw_release)
      |=> !scl_oe_n_q;
  endproperty
  a_hold: assert property (p_hold) else $error("clock released without service");

  property p_timeout;
    @(posedge clk) disable iff (srst)
    to_hit |=> (to_flag_q && !to_en_q && !to_run_q && state_q == ise_pkg::ST_IDLE && received_ack_flag_q);
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out did not reset engine");

  property p_drive_low;
    @(posedge clk) disable iff (srst)
    1'b1 |-> (!scl_o && !sda_o);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("line driven high");
endmodule : ise_i2c_slave_engine

// ### tb/ise_bus_master.sv
// two-wire bus master model with open-drain lines
module ise_bus_master (
  // device drive enables
  input  wire logic dev_scl_oe_n,
  input  wire logic dev_sda_oe_n,
  // wire levels
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_m     = 1'b1;
  logic sda_m     = 1'b1;
  logic stall_err = 1'b0;
  // pull-ups: a released line reads high
  assign scl = scl_m & dev_scl_oe_n;
  assign sda = sda_m & dev_sda_oe_n;
  // data moves mid-low, away from clock edges
  task automatic bit_x(input logic b, output logic r);
    int n;
    #40 sda_m = b;
    #40 scl_m = 1'b1;
    for (n = 0; n < 400 && !scl; n++) #10;
    if (!scl) stall_err = 1'b1;
    #80 r = sda;
    scl_m = 1'b0;
  endtask : bit_x
  task automatic start();
    sda_m = 1'b1;
    scl_m = 1'b1;
    #80 sda_m = 1'b0;
    #80 scl_m = 1'b0;
  endtask : start
  task automatic stop();
    #40 sda_m = 1'b0;
    #40 scl_m = 1'b1;
    #80 sda_m = 1'b1;
    #80;
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic ackv, output logic [7:0] r, output logic ak);
    int i;
    logic b;
    for (i = 7; i >= 0; i--) begin
      bit_x(d[i], b);
      r[i] = b;
    end
    bit_x(ackv, ak);
    // slave acts on the ninth fall only after its filter delay
    #100;
  endtask : xfer
endmodule : ise_bus_master

// ### tb/tb_top.sv
// self-checking bench of the two-wire slave engine
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [2:0] a; logic [7:0] d;} ise_row_s;
  logic       clk       = 1'b0;
  logic       srst      = 1'b1;
  logic [2:0] reg_addr  = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic       scl_i, scl_oe_n, sda_i, sda_oe_n, irq, wake;
  int         fail_count  = 0;
  int         comparisons = 0;
  int         cycles      = 0;
  int         irq_n       = 0;
  int         wake_n      = 0;
  logic [7:0] v;
  logic       ak;
  // register rows: write, or read with expected value
  ise_row_s rows [11] = '{'{1'b0, 3'h1, 8'h81}, '{1'b0, 3'h0, 8'hE0}, '{1'b1, 3'h0, 8'hDE},
    '{1'b0, 3'h0, 8'hCE}, '{1'b1, 3'h3, 8'hA5}, '{1'b0, 3'h3, 8'hA5}, '{1'b1, 3'h5, 8'h77},
    '{1'b0, 3'h5, 8'h00}, '{1'b0, 3'h4, 8'h00}, '{1'b1, 3'h1, 8'h02}, '{1'b0, 3'h1, 8'h83}};
  ise_i2c_slave_engine #(.TOUT_UNIT_CYC(8)) ise_i2c_slave_engine_inst (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_i), .scl_o(), .scl_oe_n(scl_oe_n),
    .sda_i(sda_i), .sda_o(), .sda_oe_n(sda_oe_n), .irq(irq), .wake(wake));
  ise_bus_master m_inst (.dev_scl_oe_n(scl_oe_n), .dev_sda_oe_n(sda_oe_n), .scl(scl_i), .sda(sda_i));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (irq === 1'b1) irq_n++;
    if (wake === 1'b1) wake_n++;
    if (cycles == 30000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k].wr) begin
        wr(rows[k].a, rows[k].d);
      end else begin
        rd(rows[k].a, v);
        chk(v, rows[k].d);
      end
    end
    $display("test registers done");
    irq_n = 0;
    m_inst.start();
    m_inst.xfer(8'hA4, 1'b1, v, ak);
    chk({7'h0, ak}, 8'h00);
    chk({7'h0, scl_oe_n}, 8'h00);
    rd(ise_pkg::ADDR_STAT, v);
    chk(v, 8'hE3);
    rd(ise_pkg::ADDR_DATA, v);
    m_inst.xfer(8'h3C, 1'b1, v, ak);
    chk({7'h0, ak}, 8'h00);
    rd(ise_pkg::ADDR_DATA, v);
    chk(v, 8'h3C);
    wr(ise_pkg::ADDR_STAT, 8'h0A);
    m_inst.xfer(8'h5A, 1'b1, v, ak);
    chk({7'h0, ak}, 8'h01);
    rd(ise_pkg::ADDR_DATA, v);
    chk(v, 8'h5A);
    wr(ise_pkg::ADDR_STAT, 8'h00);
    m_inst.stop();
    rd(ise_pkg::ADDR_STAT, v);
    chk(v & 8'h20, 8'h00);
    chk(8'(irq_n), 8'h03);
    chk(8'(wake_n), 8'h01);
    $display("test receive done");
    wr(ise_pkg::ADDR_MODE, 8'hC6);
    m_inst.start();
    m_inst.xfer(8'h40, 1'b1, v, ak);
    chk({7'h0, ak}, 8'h01);
    m_inst.stop();
    $display("test foreign address done");
    wr(ise_pkg::ADDR_MODE, 8'hC2);
    m_inst.start();
    m_inst.xfer(8'hA5, 1'b1, v, ak);
    rd(ise_pkg::ADDR_STAT, v);
    chk(v & 8'h04, 8'h04);
    wr(ise_pkg::ADDR_STAT, 8'h10);
    wr(ise_pkg::ADDR_DATA, 8'hA7);
    m_inst.xfer(8'hFF, 1'b1, v, ak);
    chk(v, 8'hA7);
    rd(ise_pkg::ADDR_STAT, v);
    chk(v & 8'h01, 8'h01);
    chk({6'h0, sda_oe_n, scl_oe_n}, 8'h03);
    m_inst.stop();
    $display("test transmit done");
    wr(ise_pkg::ADDR_MODE, 8'hCC);
    m_inst.start();
    m_inst.xfer(8'hA4, 1'b1, v, ak);
    chk({7'h0, ak}, 8'h01);
    m_inst.stop();
    wr(ise_pkg::ADDR_MODE, 8'hCE);
    rd(ise_pkg::ADDR_STAT, v);
    chk(v, 8'h91);
    chk({7'h0, m_inst.stall_err}, 8'h00);
    $display("test enable done");
    wr(ise_pkg::ADDR_TOUT, 8'h83);
    irq_n = 0;
    m_inst.start();
    m_inst.xfer(8'hA4, 1'b1, v, ak);
    repeat (40) @(posedge clk);
    rd(ise_pkg::ADDR_TOUT, v);
    chk(v, 8'h43);
    rd(ise_pkg::ADDR_STAT, v);
    chk(v, 8'h81);
    chk({7'h0, scl_oe_n}, 8'h01);
    chk(8'(irq_n), 8'h02);
    m_inst.stop();
    $display("test time-out done");
    end_sim();
  end
endmodule : tb_top
